// [shared/fcs_defines.svh]
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// Function
// - Identifier mode persists until new command
// - Host verifies each byte with fresh command (after an erase the host verifies only req_addr)
// - Failed byte: erase again, resume there (the host only clears rsp_ok and ends the op)
// - Host ends verify with another command
// - Abort: two reset writes, then command
// - Write: select low, strobe pulsed low
`define FCS_CMD_READ 8'h00
`define FCS_CMD_IDENT 8'h90
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_ERASE_CHECK 8'hA0
`define FCS_CMD_PROG_SETUP 8'h40
`define FCS_CMD_PROG_CHECK 8'hC0
`define FCS_CMD_RESET 8'hFF
`define FCS_ERASED_BYTE 8'hFF
`define FCS_CLK_MHZ 200
`define FCS_T_PHASE_NS 100
`define FCS_PHASE_CYC ((`FCS_T_PHASE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_T_PROG_US 10
`define FCS_PROG_CYC (`FCS_T_PROG_US * `FCS_CLK_MHZ)
`define FCS_T_ERASE_MS 10
`define FCS_ERASE_CYC (`FCS_T_ERASE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_LAST_ADDR 18'h3_FFFF
`endif

// [shared/fcs_pkg.sv]
package fcs_pkg;
    typedef enum logic [7:0] {
        FCS_OP_READ = 8'h01,
        FCS_OP_IDENT = 8'h02,
        FCS_OP_ERASE = 8'h04,
        FCS_OP_PROGRAM = 8'h08,
        FCS_OP_RESET = 8'h10
    } fcs_op_t;

    typedef enum logic [6:0] {
        FCS_IDLE = 7'b000_0001,
        FCS_W_LOW = 7'b000_0010,
        FCS_W_HIGH = 7'b000_0100,
        FCS_R_LOW = 7'b000_1000,
        FCS_R_DONE = 7'b001_0000,
        FCS_PULSE = 7'b010_0000,
        FCS_DONE = 7'b100_0000
    } fcs_bus_t;

    typedef struct packed {
        fcs_bus_t bus;
        logic [3:0] step;
        logic [31:0] cnt;
        logic [17:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic dq_oe;
        logic done;
        logic ok;
        fcs_op_t op;
    } fcs_state_t;
endpackage

// [rtl/fcs_host.sv]
`include "fcs_defines.svh"
module fcs_host import fcs_pkg::*; #(
    parameter int PROG_CYC = `FCS_PROG_CYC,
    parameter int ERASE_CYC = `FCS_ERASE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic req_valid,
    output logic req_ready,
    input wire fcs_op_t req_op,
    input wire logic [17:0] req_addr,
    input wire logic [7:0] req_data,
    output logic rsp_done,
    output logic rsp_ok,
    output logic [7:0] rsp_data,
    input wire logic vpp_high,
    output logic [17:0] flash_addr,
    output logic flash_ce_b,
    output logic flash_oe_b,
    output logic flash_we_b,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in
);
    localparam int PHASE = `FCS_PHASE_CYC;

    fcs_state_t s_r, s_nxt;

    // Command script: each step is a write, read or timed pulse
    function automatic logic [9:0] step_of(fcs_op_t op, logic [3:0] k, logic [7:0] d);
        // returns {kind[1:0], data}; kind 1=write 2=read 3=pulse 0=end
        logic [9:0] r;
        r = 10'h000;
        case (op)
            FCS_OP_READ: case (k)
                4'h0: r = {2'd1, `FCS_CMD_READ};
                4'h1: r = {2'd2, 8'h00};
                default: r = 10'h000;
            endcase
            FCS_OP_IDENT: case (k)
                4'h0: r = {2'd1, `FCS_CMD_IDENT};
                4'h1: r = {2'd2, 8'h00};
                4'h2: r = {2'd1, `FCS_CMD_READ};
                default: r = 10'h000;
            endcase
            FCS_OP_ERASE: case (k)
                4'h0: r = {2'd1, `FCS_CMD_ERASE};
                4'h1: r = {2'd1, `FCS_CMD_ERASE};
                4'h2: r = {2'd3, 8'h00};
                4'h3: r = {2'd1, `FCS_CMD_ERASE_CHECK};
                4'h4: r = {2'd2, 8'h00};
                4'h5: r = {2'd1, `FCS_CMD_READ};
                default: r = 10'h000;
            endcase
            FCS_OP_PROGRAM: case (k)
                4'h0: r = {2'd1, `FCS_CMD_PROG_SETUP};
                4'h1: r = {2'd1, d};
                4'h2: r = {2'd3, 8'h00};
                4'h3: r = {2'd1, `FCS_CMD_PROG_CHECK};
                4'h4: r = {2'd2, 8'h00};
                4'h5: r = {2'd1, `FCS_CMD_READ};
                default: r = 10'h000;
            endcase
            FCS_OP_RESET: case (k)
                4'h0: r = {2'd1, `FCS_CMD_RESET};
                4'h1: r = {2'd1, `FCS_CMD_RESET};
                4'h2: r = {2'd1, `FCS_CMD_READ};
                default: r = 10'h000;
            endcase
            default: r = 10'h000;
        endcase
        return r;
    endfunction

    // Only the listed ops have a script; anything else is answered at once
    function automatic logic op_known(fcs_op_t op);
        logic r;
        r = 1'b0;
        case (op)
            FCS_OP_READ, FCS_OP_IDENT, FCS_OP_ERASE, FCS_OP_PROGRAM, FCS_OP_RESET: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic [9:0] cur;
    assign cur = step_of(s_r.op, s_r.step, s_r.wdata);
    assign req_ready = (s_r.bus == FCS_IDLE);
    assign rsp_done = s_r.done;
    assign rsp_ok = s_r.ok;
    assign rsp_data = s_r.rdata;
    assign flash_addr = s_r.addr;
    assign flash_ce_b = s_r.ce_b;
    assign flash_oe_b = s_r.oe_b;
    assign flash_we_b = s_r.we_b;
    assign dq_oe = s_r.dq_oe;
    assign dq_out = cur[7:0];

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.bus)
            FCS_IDLE: begin
                if (req_valid) begin
                    s_nxt.op = req_op;
                    s_nxt.addr = req_addr;
                    s_nxt.wdata = req_data;
                    s_nxt.step = 4'h0;
                    s_nxt.ok = 1'b1;
                    // Without high supply writes would be ignored; refuse
                    if (!op_known(req_op)) begin
                        s_nxt.ok = 1'b0;
                        s_nxt.bus = FCS_DONE;
                    end else if (!vpp_high && req_op != FCS_OP_READ) begin
                        s_nxt.ok = 1'b0;
                        s_nxt.bus = FCS_DONE;
                    end else if (!vpp_high) begin
                        s_nxt.step = 4'h1;
                        s_nxt.bus = FCS_R_LOW;
                        s_nxt.ce_b = 1'b0;
                        s_nxt.oe_b = 1'b0;
                        s_nxt.cnt = 32'd0;
                    end else begin
                        s_nxt.bus = FCS_W_HIGH;
                        s_nxt.cnt = 32'd0;
                    end
                end
            end
            FCS_W_HIGH: begin
                // Dispatch next script step
                s_nxt.cnt = 32'd0;
                case (cur[9:8])
                    2'd1: begin
                        s_nxt.bus = FCS_W_LOW;
                        s_nxt.ce_b = 1'b0;
                        s_nxt.we_b = 1'b0;
                        s_nxt.dq_oe = 1'b1;
                    end
                    2'd2: begin
                        s_nxt.bus = FCS_R_LOW;
                        s_nxt.ce_b = 1'b0;
                        s_nxt.oe_b = 1'b0;
                    end
                    2'd3: s_nxt.bus = FCS_PULSE;
                    default: s_nxt.bus = FCS_DONE;
                endcase
                // Supply lost mid-script: later writes would be dropped, so stop here
                if (!vpp_high && cur[9:8] != 2'd0) begin
                    s_nxt.ce_b = 1'b1;
                    s_nxt.we_b = 1'b1;
                    s_nxt.oe_b = 1'b1;
                    s_nxt.dq_oe = 1'b0;
                    s_nxt.ok = 1'b0;
                    s_nxt.bus = FCS_DONE;
                end
            end
            FCS_W_LOW: begin
                s_nxt.cnt = s_r.cnt + 32'd1;
                // Data held through the rising strobe edge
                if (s_r.cnt == 32'(PHASE)) begin
                    s_nxt.we_b = 1'b1;
                end
                if (s_r.cnt == 32'(2 * PHASE)) begin
                    s_nxt.ce_b = 1'b1;
                    s_nxt.dq_oe = 1'b0;
                    s_nxt.step = s_r.step + 4'h1;
                    s_nxt.bus = FCS_W_HIGH;
                end
            end
            FCS_R_LOW: begin
                s_nxt.cnt = s_r.cnt + 32'd1;
                if (s_r.cnt == 32'(PHASE)) begin
                    s_nxt.rdata = dq_in;
                    s_nxt.ce_b = 1'b1;
                    s_nxt.oe_b = 1'b1;
                    s_nxt.bus = FCS_R_DONE;
                end
            end
            FCS_R_DONE: begin
                // Erase check fails unless all ones
                if (s_r.op == FCS_OP_ERASE && s_r.rdata != `FCS_ERASED_BYTE) begin
                    s_nxt.ok = 1'b0;
                end
                if (s_r.op == FCS_OP_PROGRAM && s_r.rdata != s_r.wdata) begin
                    s_nxt.ok = 1'b0;
                end
                s_nxt.step = s_r.step + 4'h1;
                s_nxt.bus = vpp_high ? FCS_W_HIGH : FCS_DONE;
                s_nxt.cnt = 32'd0;
            end
            FCS_PULSE: begin
                // Pulse length set by host; device stop timer is only a backstop
                s_nxt.cnt = s_r.cnt + 32'd1;
                if (s_r.cnt == 32'((s_r.op == FCS_OP_ERASE) ? ERASE_CYC : PROG_CYC)) begin
                    s_nxt.step = s_r.step + 4'h1;
                    s_nxt.bus = FCS_W_HIGH;
                end
            end
            FCS_DONE: begin
                s_nxt.done = 1'b1;
                s_nxt.bus = FCS_IDLE;
            end
            // A state code off the one-hot set parks the pins and drops the op
            default: begin
                s_nxt.ce_b = 1'b1;
                s_nxt.oe_b = 1'b1;
                s_nxt.we_b = 1'b1;
                s_nxt.dq_oe = 1'b0;
                s_nxt.ok = 1'b0;
                s_nxt.bus = FCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_r <= '{bus: FCS_IDLE, step: 4'h0, cnt: 32'd0, addr: 18'h0_0000,
                     wdata: 8'h00, rdata: 8'h00, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1,
                     dq_oe: 1'b0, done: 1'b0, ok: 1'b0, op: FCS_OP_READ};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// [bench/fcs_host_chk.sv]
module fcs_host_chk import fcs_pkg::*; (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire fcs_op_t req_op,
    input wire logic vpp_high,
    input wire logic rsp_done,
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_b,
    input wire logic flash_oe_b,
    input wire logic flash_we_b,
    input wire logic dq_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire take = req_valid && req_ready;
    chk_we_sel: assert property (!flash_we_b |-> !flash_ce_b)
        else $error("we_b low without ce_b");
    chk_read_quiet: assert property (!flash_oe_b |-> flash_we_b && !dq_oe)
        else $error("bus clash");
    chk_drive_sel: assert property (dq_oe |-> !flash_ce_b)
        else $error("dq driven while idle");
    chk_we_width: assert property ($fell(flash_we_b) |-> (!flash_we_b throughout ##20 1'b1))
        else $error("we pulse short");
    chk_addr_hold: assert property (!flash_ce_b && $past(!flash_ce_b) |-> $stable(flash_addr))
        else $error("address moved");
    chk_refuse_low: assert property (take && !vpp_high && req_op != FCS_OP_READ
        |=> flash_ce_b && flash_we_b ##1 flash_ce_b && flash_we_b && rsp_done)
        else $error("pins moved on locked op");
    chk_one_op: assert property (take |=> !req_ready)
        else $error("second op accepted");
    chk_done_bound: assert property (take |-> ##[1:1000] rsp_done)
        else $error("op never done");
endmodule
bind fcs_host fcs_host_chk fcs_host_chk_i (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .vpp_high(vpp_high), .rsp_done(rsp_done),
    .flash_addr(flash_addr), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b), .dq_oe(dq_oe));

// [bench/fcs_flash.sv]
module fcs_flash #(
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART = 8'hC3 // Arbitrary value
) (
    input wire logic vpp_high,
    input wire logic [17:0] addr,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic [7:0] bus,
    output logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [logic [17:0]];
    logic [7:0] cmd = 8'h00;
    logic [7:0] val = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] pgm_v;
    logic [17:0] lat_a, pgm_a, chk_a;
    int st = 0;
    function automatic logic [7:0] rd(logic [17:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    // Select and strobe fall on one edge; latch on whichever settles last
    always @(negedge we_b or negedge ce_b) if (!ce_b && !we_b) lat_a = addr;
    always @(posedge we_b) begin
        if (!ce_b && !vpp_high) begin
            cmd = 8'h00;
            st = 0;
        end else if (!ce_b && st == 3) begin
            pgm_a = lat_a;
            pgm_v = bus;
            st = 4;
        end else if (!ce_b) begin
            // Programming only clears bits, so a reprogram can fail its check
            if (st == 4 && bus == 8'hC0) mem[pgm_a] = rd(pgm_a) & pgm_v;
            if (st == 2 && bus == 8'hA0) mem.delete();
            if (bus == 8'hA0) chk_a = lat_a;
            st = bus == 8'h40 ? 3 : bus != 8'h20 ? 0 : st == 1 ? 2 : 1;
            cmd = bus;
        end
    end
    always @(cmd or addr or chk_a or pgm_a or oe_b or vpp_high) begin
        case (vpp_high ? cmd : 8'h00)
            8'h90: val = addr == 18'h0 ? MAKER : addr == 18'h1 ? PART : 8'h00;
            8'hA0: val = rd(chk_a);
            8'hC0: val = rd(pgm_a);
            default: val = rd(addr);
        endcase
    end
    always @(posedge oe_b) last = val;
    // Released bus shows the inverse so stale data cannot pass a check
    assign dq = !ce_b && !oe_b ? val : ~last;
endmodule

// [bench/test_fcs_host.sv]
module test_fcs_host import fcs_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rst_b = 0, req_valid = 0, vpp_high = 1;
    fcs_op_t req_op = FCS_OP_READ;
    logic [17:0] req_addr = 0, flash_addr;
    logic [7:0] req_data = 0, rsp_data, dq_out, dq_in, bus;
    logic req_ready, rsp_done, rsp_ok, flash_ce_b, flash_oe_b, flash_we_b, dq_oe;
    int failures = 0, n_compared = 0;
    logic [31:0] seed = 73;
    logic [7:0] sh [logic [17:0]];
    assign bus = dq_oe ? dq_out : dq_in;
    fcs_host #(.PROG_CYC(20), .ERASE_CYC(50)) fcs_host_i (.clock(clock), .rst_b(rst_b),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .rsp_done(rsp_done), .rsp_ok(rsp_ok), .rsp_data(rsp_data),
        .vpp_high(vpp_high), .flash_addr(flash_addr), .flash_ce_b(flash_ce_b),
        .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in));
    fcs_flash #(.MAKER(8'h5A), .PART(8'hC3)) fcs_flash_i (.vpp_high(vpp_high),
        .addr(flash_addr), .ce_b(flash_ce_b), .oe_b(flash_oe_b), .we_b(flash_we_b),
        .bus(bus), .dq(dq_in));
    initial begin
        forever #2.5 clock = ~clock;
    end
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] shv(logic [17:0] a);
        return sh.exists(a) ? sh[a] : 8'hFF;
    endfunction
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    // Valid is held until the edge that samples ready high
    task automatic op(fcs_op_t o, logic [17:0] a, logic [7:0] d);
        int n;
        n = 0;
        req_valid = 1;
        req_op = o;
        req_addr = a;
        req_data = d;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clock) #1 n++;
        end
        @(posedge clock) #1 req_valid = 0;
        while (rsp_done !== 1'b1 && n < 3000) begin
            @(posedge clock) #1 n++;
        end
        if (n >= 3000) begin
            failures++;
            end_sim();
        end
        @(posedge clock) #1;
    endtask
    initial begin
        logic [17:0] a;
        logic [7:0] d;
        repeat (10) @(posedge clock);
        #1 rst_b = 1;
        op(FCS_OP_READ, 18'h0_0005, 8'h00);
        cmp("read", 8'hFF, rsp_data);
        op(FCS_OP_IDENT, 18'h0_0000, 8'h00);
        cmp("maker", 8'h5A, rsp_data);
        op(FCS_OP_IDENT, 18'h0_0001, 8'h00);
        cmp("part", 8'hC3, rsp_data);
        repeat (8) begin
            seed = xs(seed);
            a = {15'h0, seed[2:0]};
            d = seed[15:8];
            op(FCS_OP_PROGRAM, a, d);
            cmp("prog ok", {7'h0, (shv(a) & d) == d}, {7'h0, rsp_ok});
            sh[a] = shv(a) & d;
            op(FCS_OP_READ, a, 8'h00);
            cmp("prog read", sh[a], rsp_data);
        end
        vpp_high = 0;
        op(FCS_OP_PROGRAM, a, 8'h00);
        cmp("locked prog", 8'h00, {7'h0, rsp_ok});
        op(FCS_OP_ERASE, a, 8'h00);
        cmp("locked erase", 8'h00, {7'h0, rsp_ok});
        op(FCS_OP_READ, a, 8'h00);
        cmp("locked read", sh[a], rsp_data);
        vpp_high = 1;
        op(FCS_OP_RESET, a, 8'h00);
        op(FCS_OP_READ, a, 8'h00);
        cmp("reset read", sh[a], rsp_data);
        op(FCS_OP_ERASE, a, 8'h00);
        cmp("erase ok", 8'h01, {7'h0, rsp_ok});
        sh.delete();
        op(FCS_OP_READ, a, 8'h00);
        cmp("erased", shv(a), rsp_data);
        end_sim();
    end
endmodule
